// file: verilog/opfc_top.sv
// Operand bus master with fault register, registers reached over AHB-Lite
`default_nettype none

module opfc_top (
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic [1:0]       hresp_o,
    output logic [31:0]      hrdata_o,
    // Device pins
    input  wire logic        master_reset_n_i,
    input  wire logic        test_n_i,
    output logic             bus_req_out_n_o,
    output logic             bus_req_out_n_oe_o,
    input  wire logic        bus_grant_in_n_i,
    input  wire logic        bus_busy_in_n_i,
    output logic             owner_ack_out_n_o,
    output logic             owner_ack_out_n_oe_o,
    input  wire logic        transfer_ack_in_n_i,
    output logic             operand_not_fetch_o,
    output logic             operand_not_fetch_oe_o,
    output logic             addr_strobe_n_o,
    output logic             addr_strobe_n_oe_o,
    output logic             mem_not_io_o,
    output logic             mem_not_io_oe_o,
    output logic             read_not_write_o,
    output logic             read_not_write_oe_o,
    output logic             data_strobe_n_o,
    output logic             data_strobe_n_oe_o,
    output logic [15:0]      operand_addr_o,
    output logic             operand_addr_oe_o,
    input  wire logic [15:0] operand_data_lines_i,
    output logic [15:0]      operand_data_lines_o,
    output logic             operand_data_lines_oe_o,
    output logic [3:0]       address_state_out_o,
    output logic             address_state_out_oe_o,
    output logic [3:0]       proc_state_out_o,
    output logic             proc_state_out_oe_o,
    input  wire logic        system_fault_in_i,
    input  wire logic        bus_timeout_err_n_i,
    input  wire logic        parity_error_in_i,
    input  wire logic        protect_fault_in_i
);

    // ------------------------------------------------------------
    // Reset and test mode
    // ------------------------------------------------------------
    wire rst;
    wire test_mode;
    wire pins_on;

    // Either reset source, both synchronous
    assign rst       = srst_i | ~master_reset_n_i;
    assign test_mode = ~test_n_i;
    assign pins_on   = ~test_mode;

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    logic       wr_pend_r;
    logic       rd_pend_r;
    logic       rd_ack_r;
    logic [7:0] addr_q_r;
    logic [31:0] hrdata_r;

    wire addr_ph;
    wire wr_fire;
    wire [7:0] rd_addr;

    assign addr_ph = hsel_i & hready_i & htrans_i[1];
    assign wr_fire = wr_pend_r;
    assign rd_addr = addr_q_r;

    // Reads take one wait state
    assign hreadyout_o = ~(rd_pend_r & ~rd_ack_r);
    assign hresp_o     = opfc_pkg::HRESP_OKAY;
    assign hrdata_o    = hrdata_r;

    // Address phase kept for the data phase
    always_ff @(posedge mclk_i) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            rd_ack_r  <= 1'b0;
            addr_q_r  <= 8'h00;
        end else if (hready_i) begin
            wr_pend_r <= addr_ph & hwrite_i;
            rd_pend_r <= addr_ph & ~hwrite_i;
            rd_ack_r  <= 1'b0;
            if (addr_ph) begin
                addr_q_r <= {haddr_i[7:2], 2'b00};
            end
        end else if (rd_pend_r) begin
            rd_ack_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    wire wr_ctrl;
    wire wr_addr;
    wire wr_wdata;
    wire wr_status;
    wire wr_fault;
    wire wr_states;

    assign wr_ctrl   = wr_fire & reg_hit(addr_q_r, opfc_pkg::REG_CTRL);
    assign wr_addr   = wr_fire & reg_hit(addr_q_r, opfc_pkg::REG_ADDR);
    assign wr_wdata  = wr_fire & reg_hit(addr_q_r, opfc_pkg::REG_WDATA);
    assign wr_status = wr_fire & reg_hit(addr_q_r, opfc_pkg::REG_STATUS);
    assign wr_fault  = wr_fire & reg_hit(addr_q_r, opfc_pkg::REG_FAULT);
    assign wr_states = wr_fire & reg_hit(addr_q_r, opfc_pkg::REG_STATES);

    // ------------------------------------------------------------
    // Operand bus sequencer
    // ------------------------------------------------------------
    opfc_pkg::opfc_bus_state_t state_r;
    opfc_pkg::opfc_bus_state_t state_nxt;

    logic        cyc_io_r;
    logic        cyc_wr_r;
    logic        cyc_fetch_r;
    logic [15:0] cyc_addr_r;
    logic [15:0] cyc_wdata_r;
    logic [15:0] rdata_r;
    logic        done_r;
    logic [7:0]  states_r;

    wire start;
    wire grant_ok;
    wire own;
    wire xfer_end;
    wire requesting;

    // Go only from idle, not in test
    assign start      = wr_ctrl & hwdata_i[opfc_pkg::CTRL_GO] & ~test_mode
                        & (state_r == opfc_pkg::BUS_IDLE);
    assign grant_ok   = ~bus_grant_in_n_i & bus_busy_in_n_i & ~test_mode;
    assign own        = (state_r == opfc_pkg::BUS_ADDR) | (state_r == opfc_pkg::BUS_DATA);
    assign xfer_end   = (state_r == opfc_pkg::BUS_DATA) & ~transfer_ack_in_n_i;
    assign requesting = (state_r != opfc_pkg::BUS_IDLE);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            opfc_pkg::BUS_IDLE: begin
                if (start) begin
                    state_nxt = opfc_pkg::BUS_REQ;
                end
            end
            opfc_pkg::BUS_REQ: begin
                if (grant_ok) begin
                    state_nxt = opfc_pkg::BUS_ADDR;
                end
            end
            opfc_pkg::BUS_ADDR: begin
                state_nxt = opfc_pkg::BUS_DATA;
            end
            opfc_pkg::BUS_DATA: begin
                if (xfer_end) begin
                    state_nxt = opfc_pkg::BUS_IDLE;
                end
            end
            default: begin
                state_nxt = opfc_pkg::BUS_IDLE;
            end
        endcase

        // Test drops a cycle in flight
        if (test_mode) begin
            state_nxt = opfc_pkg::BUS_IDLE;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst) begin
            state_r <= opfc_pkg::BUS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Cycle kind latched with go
    always_ff @(posedge mclk_i) begin
        if (rst) begin
            cyc_io_r    <= 1'b0;
            cyc_wr_r    <= 1'b0;
            cyc_fetch_r <= 1'b0;
        end else if (start) begin
            cyc_io_r    <= hwdata_i[opfc_pkg::CTRL_IO];
            cyc_wr_r    <= hwdata_i[opfc_pkg::CTRL_WR];
            cyc_fetch_r <= hwdata_i[opfc_pkg::CTRL_FETCH];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst) begin
            cyc_addr_r  <= opfc_pkg::WORD16_RST;
            cyc_wdata_r <= opfc_pkg::WORD16_RST;
            states_r    <= opfc_pkg::STATES_RST;
        end else begin
            // Address and write data frozen while owning
            if (wr_addr & ~own) begin
                cyc_addr_r <= hwdata_i[15:0];
            end

            if (wr_wdata & ~own) begin
                cyc_wdata_r <= hwdata_i[15:0];
            end

            if (wr_states) begin
                states_r <= hwdata_i[7:0];
            end
        end
    end

    // Done is sticky; completion wins over a clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (rst) begin
            rdata_r <= opfc_pkg::WORD16_RST;
            done_r  <= 1'b0;
        end else begin
            if (xfer_end & ~cyc_wr_r) begin
                rdata_r <= operand_data_lines_i;
            end
            if (xfer_end) begin
                done_r <= 1'b1;
            end else if (wr_status & hwdata_i[opfc_pkg::STAT_DONE]) begin
                done_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    wire own_drive;

    assign own_drive = own & pins_on;

    // Request and fetch stay driven outside test
    assign bus_req_out_n_o         = ~requesting;
    assign bus_req_out_n_oe_o      = pins_on;

    assign owner_ack_out_n_o       = 1'b0;
    assign owner_ack_out_n_oe_o    = own_drive;

    assign operand_not_fetch_o     = ~(own & cyc_fetch_r);
    assign operand_not_fetch_oe_o  = pins_on;

    assign addr_strobe_n_o         = ~own;
    assign addr_strobe_n_oe_o      = own_drive;

    assign mem_not_io_o            = ~cyc_io_r;
    assign mem_not_io_oe_o         = own_drive;

    assign read_not_write_o        = ~cyc_wr_r;
    assign read_not_write_oe_o     = own_drive;

    assign data_strobe_n_o         = ~(state_r == opfc_pkg::BUS_DATA);
    assign data_strobe_n_oe_o      = own_drive;

    assign operand_addr_o          = cyc_addr_r;
    assign operand_addr_oe_o       = own_drive;

    assign operand_data_lines_o    = cyc_wdata_r;
    assign operand_data_lines_oe_o = own_drive & cyc_wr_r;

    assign address_state_out_o     = states_r[3:0];
    assign address_state_out_oe_o  = own_drive;

    assign proc_state_out_o        = states_r[7:4];
    assign proc_state_out_oe_o     = own_drive;

    // ------------------------------------------------------------
    // Fault register
    // ------------------------------------------------------------
    logic        system_fault_in_q_r;
    logic [15:0] fault_r;
    logic [15:0] fault_nxt;
    logic [15:0] fault_set;
    logic [15:0] fault_hold;
    logic [15:0] fault_clr;

    wire tout;

    assign tout = ~bus_timeout_err_n_i;

    always_comb begin
        fault_set  = 16'h0000;
        fault_hold = 16'h0000;
        fault_set[opfc_pkg::FLT_SYSTEM_FAULT_IN]   = system_fault_in_i & ~system_fault_in_q_r;
        fault_set[opfc_pkg::FLT_TOUT_IO]  = tout & own & cyc_io_r;
        fault_set[opfc_pkg::FLT_TOUT_MEM] = tout & own & ~cyc_io_r;
        fault_set[opfc_pkg::FLT_PARITY]   = parity_error_in_i;
        fault_set[opfc_pkg::FLT_CPU]      = protect_fault_in_i & own;
        fault_set[opfc_pkg::FLT_DMA]      = protect_fault_in_i & ~own;

        fault_hold[opfc_pkg::FLT_SYSTEM_FAULT_IN]   = system_fault_in_i;
        fault_hold[opfc_pkg::FLT_TOUT_IO]  = tout;
        fault_hold[opfc_pkg::FLT_TOUT_MEM] = tout;
        fault_hold[opfc_pkg::FLT_PARITY]   = parity_error_in_i;
        fault_hold[opfc_pkg::FLT_CPU]      = protect_fault_in_i;
        fault_hold[opfc_pkg::FLT_DMA]      = protect_fault_in_i;

        // Live cause masks its clear
        fault_clr  = wr_fault ? (hwdata_i[15:0] & ~fault_hold) : 16'h0000;
        fault_nxt  = (fault_r & ~fault_clr) | fault_set;
    end

    always_ff @(posedge mclk_i) begin
        if (rst) begin
            system_fault_in_q_r <= 1'b0;
            fault_r    <= opfc_pkg::FAULT_RST;
        end else begin
            system_fault_in_q_r <= system_fault_in_i;
            fault_r    <= fault_nxt;
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    logic [31:0] status_w;

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[opfc_pkg::STAT_ACTIVE] = requesting;
        status_w[opfc_pkg::STAT_OWN]    = own;
        status_w[opfc_pkg::STAT_DONE]   = done_r;
        status_w[opfc_pkg::STAT_TEST]   = test_mode;

        // Unmapped offsets read zero
        rd_mux = 32'h0000_0000;
        if (reg_hit(rd_addr, opfc_pkg::REG_CTRL)) begin
            rd_mux = {28'h000_0000, cyc_fetch_r, cyc_wr_r, cyc_io_r, 1'b0};
        end else if (reg_hit(rd_addr, opfc_pkg::REG_ADDR)) begin
            rd_mux = {16'h0000, cyc_addr_r};
        end else if (reg_hit(rd_addr, opfc_pkg::REG_WDATA)) begin
            rd_mux = {16'h0000, cyc_wdata_r};
        end else if (reg_hit(rd_addr, opfc_pkg::REG_RDATA)) begin
            rd_mux = {16'h0000, rdata_r};
        end else if (reg_hit(rd_addr, opfc_pkg::REG_STATUS)) begin
            rd_mux = status_w;
        end else if (reg_hit(rd_addr, opfc_pkg::REG_FAULT)) begin
            rd_mux = {16'h0000, fault_r};
        end else if (reg_hit(rd_addr, opfc_pkg::REG_STATES)) begin
            rd_mux = {24'h00_0000, states_r};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst) begin
            hrdata_r <= opfc_pkg::HRDATA_RST;
        end else if (rd_pend_r & ~rd_ack_r) begin
            hrdata_r <= rd_mux;
        end
    end

endmodule

`default_nettype wire

// file: verilog/opfc_pkg.sv
// Constants, register map and state type of the operand bus master with fault capture
// Operation
// - Request bus by driving request low
// - Take bus only while grant asserted
// - Busy low means occupied, no start
// - Hold owner acknowledge low while owning
// - Float owner acknowledge on release
// - Wait states until transfer acknowledge low
// - Fetch indicator low only on fetches
// - Address strobe low, float when unowned
// - Memory high, I/O low, float unowned
// - Read high, write low, float unowned
// - Data strobe low, float when unowned
// - Test input floats every output
// - System fault rising edge sets bit 8
// - Timeout sets bit 10 I/O, 7 memory
// - Parity error sets bit 13
// - Protect fault sets 15 owned, 14 not
// - No software clear while cause asserted
// - State outputs float in test, unowned
// - Address and data float when unowned
`default_nettype none

package opfc_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_FAULT  = 8'h14;
    localparam logic [7:0] REG_STATES = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_GO    = 0;
    localparam int CTRL_IO    = 1;
    localparam int CTRL_WR    = 2;
    localparam int CTRL_FETCH = 3;

    localparam int STAT_ACTIVE = 0;
    localparam int STAT_OWN    = 1;
    localparam int STAT_DONE   = 2;
    localparam int STAT_TEST   = 3;

    localparam int FLT_TOUT_MEM = 7;
    localparam int FLT_SYSTEM_FAULT_IN   = 8;
    localparam int FLT_TOUT_IO  = 10;
    localparam int FLT_PARITY   = 13;
    localparam int FLT_DMA      = 14;
    localparam int FLT_CPU      = 15;

    // ------------------------------------------------------------
    // Reset values and bus codes
    // ------------------------------------------------------------
    localparam logic [15:0] FAULT_RST  = 16'h0000;
    localparam logic [15:0] WORD16_RST = 16'h0000;
    localparam logic [7:0]  STATES_RST = 8'h00;
    localparam logic [31:0] HRDATA_RST = 32'h0000_0000;
    localparam logic [1:0]  HRESP_OKAY = 2'h0;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_REQ,
        BUS_ADDR,
        BUS_DATA
    } opfc_bus_state_t;

endpackage

`default_nettype wire

// file: dv/opfc_sva.sv
// Concurrent checks on the operand bus pins of the operand bus master
`default_nettype none

module opfc_sva (
    input wire logic       mclk_i,
    input wire logic       srst_i,
    input wire logic       master_reset_n_i,
    input wire logic       test_n_i,
    input wire logic       bus_grant_in_n_i,
    input wire logic       bus_busy_in_n_i,
    input wire logic       transfer_ack_in_n_i,
    input wire logic       bus_req_out_n_o,
    input wire logic       bus_req_out_n_oe_o,
    input wire logic       owner_ack_out_n_o,
    input wire logic       owner_ack_out_n_oe_o,
    input wire logic       operand_not_fetch_o,
    input wire logic       operand_not_fetch_oe_o,
    input wire logic       addr_strobe_n_o,
    input wire logic       addr_strobe_n_oe_o,
    input wire logic       mem_not_io_oe_o,
    input wire logic       read_not_write_o,
    input wire logic       read_not_write_oe_o,
    input wire logic       data_strobe_n_o,
    input wire logic       data_strobe_n_oe_o,
    input wire logic       operand_addr_oe_o,
    input wire logic       operand_data_lines_oe_o,
    input wire logic       address_state_out_oe_o,
    input wire logic       proc_state_out_oe_o
);
    wire logic own      = owner_ack_out_n_oe_o;
    wire logic pins_all = addr_strobe_n_oe_o & mem_not_io_oe_o & read_not_write_oe_o
                        & data_strobe_n_oe_o & operand_addr_oe_o & address_state_out_oe_o
                        & proc_state_out_oe_o;
    wire logic pins_any = addr_strobe_n_oe_o | mem_not_io_oe_o | read_not_write_oe_o
                        | data_strobe_n_oe_o | operand_addr_oe_o | address_state_out_oe_o
                        | proc_state_out_oe_o | operand_data_lines_oe_o;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i || !master_reset_n_i);

    chk_test_float: assert property (!test_n_i |-> !pins_any && !own
        && !bus_req_out_n_oe_o && !operand_not_fetch_oe_o) else $error("driven in test mode");
    chk_own_grant: assert property ($rose(own) |->
        $past(!bus_grant_in_n_i && bus_busy_in_n_i && !bus_req_out_n_o))
        else $error("bus taken without grant");
    chk_ack_held: assert property (own |-> !owner_ack_out_n_o)
        else $error("owner acknowledge not low");
    chk_float_unowned: assert property (!own |-> !pins_any)
        else $error("pin driven while not owner");
    chk_drive_owned: assert property (own |-> pins_all)
        else $error("pin floating while owner");
    chk_addr_first: assert property ($rose(own) |->
        !addr_strobe_n_o && data_strobe_n_o ##1 !data_strobe_n_o)
        else $error("strobe order wrong");
    chk_wait_state: assert property (own && !data_strobe_n_o && transfer_ack_in_n_i
        && test_n_i |=> own && !data_strobe_n_o) else $error("cycle ended without ack");
    chk_ack_ends: assert property (own && !data_strobe_n_o && !transfer_ack_in_n_i
        |=> !own && bus_req_out_n_o) else $error("cycle not ended after ack");
    chk_write_drive: assert property (operand_data_lines_oe_o |->
        own && !read_not_write_o) else $error("data driven outside write");
    chk_fetch_owned: assert property (!operand_not_fetch_o |-> own)
        else $error("fetch low outside owned cycle");
endmodule

`default_nettype wire

// file: dv/opfc_bus_partner.sv
// Model of the arbiter, other masters and memory on the operand bus
`default_nettype none

module opfc_bus_partner (
    input  wire logic        mclk_i,
    input  wire logic        bus_req_out_n_i,
    input  wire logic        data_strobe_n_i,
    input  wire logic        data_strobe_n_oe_i,
    input  wire logic        read_not_write_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        grant_en_i,
    input  wire logic        busy_i,
    input  wire logic [3:0]  ack_wait_i,
    output logic             bus_grant_in_n_o,
    output logic             bus_busy_in_n_o,
    output logic             transfer_ack_in_n_o,
    output logic [15:0]      rdata_o
);
    logic [3:0]  wait_r = 4'h0;
    logic [15:0] last_r = 16'h0000;
    logic [15:0] mem_r  = 16'h5A3C;
    wire logic   ds_on  = data_strobe_n_oe_i & ~data_strobe_n_i;

    assign bus_grant_in_n_o    = ~(grant_en_i & ~bus_req_out_n_i);
    assign bus_busy_in_n_o     = ~busy_i;
    assign transfer_ack_in_n_o = ~(ds_on & (wait_r >= ack_wait_i));
    // Undriven data lines toggle so stale values never look valid
    assign rdata_o = (ds_on & read_not_write_i) ? mem_r : ~last_r;

    always_ff @(posedge mclk_i) begin
        wait_r <= ds_on ? wait_r + 4'h1 : 4'h0;
        last_r <= rdata_o;
        if (ds_on & ~read_not_write_i & ~transfer_ack_in_n_o) begin
            mem_r <= wdata_i;
        end
    end
endmodule

`default_nettype wire

// file: dv/opfc_top_tb.sv
// Self-checking testbench of the operand bus master with fault capture
`default_nettype none

module opfc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i, srst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, master_reset_n_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
    logic [1:0]  htrans_i, hresp_o;
    logic [2:0]  hsize_i;
    logic        test_n_i, bus_req_out_n_o, bus_req_out_n_oe_o, bus_grant_in_n_i;
    logic        bus_busy_in_n_i, owner_ack_out_n_o, owner_ack_out_n_oe_o, transfer_ack_in_n_i;
    logic        operand_not_fetch_o, operand_not_fetch_oe_o, addr_strobe_n_o, mem_not_io_o;
    logic        addr_strobe_n_oe_o, mem_not_io_oe_o, read_not_write_o, read_not_write_oe_o;
    logic        data_strobe_n_o, data_strobe_n_oe_o, operand_addr_oe_o, proc_state_out_oe_o;
    logic        operand_data_lines_oe_o, address_state_out_oe_o, system_fault_in_i;
    logic        bus_timeout_err_n_i, parity_error_in_i, protect_fault_in_i, grant_en, busy_on;
    logic [15:0] operand_addr_o, operand_data_lines_i, operand_data_lines_o, rd_word;
    logic [3:0]  address_state_out_o, proc_state_out_o, ack_wait;
    logic [3:0]  codes [4] = '{4'h1, 4'h3, 4'h5, 4'h9};
    int          errors, comparisons;

    assign hready_i = hreadyout_o;
    assign operand_data_lines_i = operand_data_lines_oe_o ? operand_data_lines_o : rd_word;

    opfc_top u_opfc_top (.*);
    opfc_bus_partner u_opfc_bus_partner (.mclk_i(mclk_i), .bus_req_out_n_i(bus_req_out_n_o),
        .data_strobe_n_i(data_strobe_n_o), .data_strobe_n_oe_i(data_strobe_n_oe_o),
        .read_not_write_i(read_not_write_o), .wdata_i(operand_data_lines_o),
        .grant_en_i(grant_en), .busy_i(busy_on), .ack_wait_i(ack_wait),
        .bus_grant_in_n_o(bus_grant_in_n_i), .bus_busy_in_n_o(bus_busy_in_n_i),
        .transfer_ack_in_n_o(transfer_ack_in_n_i), .rdata_o(rd_word));

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk_i);
        hsel_i   <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i  <= 32'(a);
        hwrite_i <= wr;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        hsel_i   <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task wait_own;
        do @(negedge mclk_i); while (addr_strobe_n_oe_o !== 1'b1);
    endtask

    task wait_free;
        do @(negedge mclk_i); while (owner_ack_out_n_oe_o === 1'b1);
    endtask

    task results;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        chk(32'({bus_req_out_n_o, bus_req_out_n_oe_o, owner_ack_out_n_oe_o}), 32'h6);
        rdchk(opfc_pkg::REG_FAULT, 32'h0000_0000);
        rdchk(opfc_pkg::REG_STATUS, 32'h0000_0000);
        rdchk(8'h1C, 32'h0000_0000);
    endtask

    task t_cycles;
        int n;
        ahb(1'b1, opfc_pkg::REG_STATES, 32'h0000_00A5);
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, opfc_pkg::REG_ADDR, 32'h0000_1230 + 32'(i));
            ahb(1'b1, opfc_pkg::REG_WDATA, 32'h0000_A5C0 + 32'(i));
            ack_wait <= 4'(i);
            ahb(1'b1, opfc_pkg::REG_CTRL, 32'(codes[i]));
            wait_own;
            chk(32'(operand_addr_o), 32'h0000_1230 + 32'(i));
            chk(32'({proc_state_out_o, address_state_out_o}), 32'h0000_00A5);
            chk(32'({mem_not_io_o, read_not_write_o, operand_not_fetch_o}),
                32'({~codes[i][1], ~codes[i][2], ~codes[i][3]}));
            n = 0;
            do begin
                @(negedge mclk_i);
                if ({data_strobe_n_oe_o, data_strobe_n_o} === 2'b10) begin
                    n++;
                    if (codes[i][2]) chk(32'(operand_data_lines_o), 32'h0000_A5C0 + 32'(i));
                end
            end while (owner_ack_out_n_oe_o === 1'b1);
            chk(32'(n), 32'(i + 1));
            ahb(1'b0, opfc_pkg::REG_RDATA, 32'h0000_0000);
            if (!codes[i][2]) chk(rd, (i == 3) ? 32'h0000_A5C2 : 32'h0000_5A3C);
        end
    endtask

    task t_arb;
        @(posedge mclk_i);
        grant_en <= 1'b0;
        ack_wait <= 4'h0;
        ahb(1'b1, opfc_pkg::REG_CTRL, 32'h0000_0001);
        repeat (5) @(posedge mclk_i);
        chk(32'({bus_req_out_n_o, owner_ack_out_n_oe_o}), 32'h0);
        grant_en <= 1'b1;
        busy_on  <= 1'b1;
        repeat (5) @(posedge mclk_i);
        chk(32'({bus_req_out_n_o, owner_ack_out_n_oe_o}), 32'h0);
        busy_on <= 1'b0;
        wait_own;
        wait_free;
    endtask

    task t_faults;
        @(posedge mclk_i);
        system_fault_in_i <= 1'b1;
        rdchk(opfc_pkg::REG_FAULT, 32'h0000_0100);
        ahb(1'b1, opfc_pkg::REG_FAULT, 32'h0000_FFFF);
        rdchk(opfc_pkg::REG_FAULT, 32'h0000_0100);
        system_fault_in_i <= 1'b0;
        ahb(1'b1, opfc_pkg::REG_FAULT, 32'h0000_FFFF);
        parity_error_in_i <= 1'b1;
        rdchk(opfc_pkg::REG_FAULT, 32'h0000_2000);
        parity_error_in_i <= 1'b0;
        ahb(1'b1, opfc_pkg::REG_FAULT, 32'h0000_FFFF);
        protect_fault_in_i <= 1'b1;
        rdchk(opfc_pkg::REG_FAULT, 32'h0000_4000);
        protect_fault_in_i <= 1'b0;
        ahb(1'b1, opfc_pkg::REG_FAULT, 32'h0000_FFFF);
        ack_wait <= 4'h6;
        for (int j = 0; j < 2; j++) begin
            ahb(1'b1, opfc_pkg::REG_CTRL, j ? 32'h0000_0003 : 32'h0000_0001);
            wait_own;
            @(posedge mclk_i);
            protect_fault_in_i  <= 1'b1;
            bus_timeout_err_n_i <= 1'b0;
            @(posedge mclk_i);
            protect_fault_in_i  <= 1'b0;
            bus_timeout_err_n_i <= 1'b1;
            wait_free;
            rdchk(opfc_pkg::REG_FAULT, j ? 32'h0000_8400 : 32'h0000_8080);
            ahb(1'b1, opfc_pkg::REG_FAULT, 32'h0000_FFFF);
        end
        rdchk(opfc_pkg::REG_FAULT, 32'h0000_0000);
    endtask

    task t_test;
        @(posedge mclk_i);
        test_n_i <= 1'b0;
        @(negedge mclk_i);
        chk(32'({bus_req_out_n_oe_o, operand_not_fetch_oe_o, owner_ack_out_n_oe_o}), 32'h0);
        ahb(1'b0, opfc_pkg::REG_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0008, 32'h0000_0008);
        master_reset_n_i <= 1'b0;
        @(posedge mclk_i);
        test_n_i <= 1'b1;
        @(posedge mclk_i);
        master_reset_n_i <= 1'b1;
        @(negedge mclk_i);
        chk(32'({bus_req_out_n_o, bus_req_out_n_oe_o}), 32'h3);
        rdchk(opfc_pkg::REG_STATUS, 32'h0000_0000);
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    initial begin
        #200us;
        errors++;
        results();
    end

    initial begin
        {srst_i, master_reset_n_i, test_n_i, bus_timeout_err_n_i, grant_en} = 5'h1F;
        {hsel_i, hwrite_i, system_fault_in_i, parity_error_in_i, protect_fault_in_i} = 5'h00;
        busy_on  = 1'b0;
        haddr_i  = 32'h0000_0000;
        hwdata_i = 32'h0000_0000;
        htrans_i = 2'h0;
        hsize_i  = 3'h2;
        ack_wait = 4'h0;
        repeat (3) @(posedge mclk_i);
        srst_i <= 1'b0;
        t_reset();
        t_cycles();
        t_arb();
        t_faults();
        t_test();
        results();
    end
endmodule

bind opfc_top opfc_sva u_opfc_sva (.*);

`default_nettype wire
